/* File: core/ssp_spi_master.sv */
`timescale 1ns/10ps
// Function
// (R1) SPI runs only while the mode field equals 2.
// (R2) Only SPI is served here; any other mode leaves the engine stopped.
// (R3) Every character is exactly eight bits.
// (R4) The engine shifts only when the master bit is set.
// (R5) Bit rate is 24 MHz / (2 * (linear + 1) * 2^exponent).
// (R6) Exponent and linear fields each take 0 to 15.
// (R7) Polarity and phase select the frame; order bit picks MSB or LSB first.
// (R8) Transmit bits leave on MOSI; receive bits are sampled from MISO.
// (R9) Slave selects come from software-driven GPIO outside this block.
// (R10) Transmit and receive each buffer four bytes.
// (R11) Idle flag clears when a byte is queued, sets when all bytes are out.
// (R12) Space flag clears on full transmit FIFO, sets when a slot frees.
// (R13) Received bytes enter the receive FIFO; valid flag shows unread data.
// (R14) Byte arriving at full receive FIFO is lost; overrun flag and interrupt raise.
// (R15) DMA overrun error shows only after the receive FIFO has drained.
// (R16) DMA error clears only by DMA reset bit or buffer reload.
// (R17) A byte is received only while one is transmitted.
// (R18) Automatic send on empty FIFO repeats last byte or sends 0xFF.
// (R19) Software changes automatic send only when idle and FIFO empty.
// (R20) Each automatic character start raises the transmit underrun flag.
// (R21) Disabling automatic send stops reception; received bytes stay.
// (R22) Polarity 1 to 0 without mode reset sends one extra 0xFE first.
// (R23) Software routes pins for three-wire master use only.
module ssp_spi_master (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ref_clk_i,
    input wire logic [1:0] serial_mode_select_i,
    input wire logic master_select_bit_i,
    input wire logic bit_order_select_i,
    input wire logic clock_phase_select_i,
    input wire logic clock_polarity_select_i,
    input wire logic repeat_select_bit_i,
    input wire logic auto_tx_enable_i,
    input wire logic [3:0] rate_exponent_reg_i,
    input wire logic [3:0] rate_linear_reg_i,
    input wire logic tx_write_i,
    input wire logic [7:0] tx_data_i,
    input wire logic rx_read_i,
    input wire logic rx_overrun_clear_i,
    input wire logic dma_reset_bits_i,
    input wire logic dma_buffer_reload_i,
    input wire logic miso_i,
    output logic mosi_o,
    output logic serial_clock_pin_o,
    output logic [7:0] rx_data_o,
    output logic tx_idle_flag_o,
    output logic tx_space_flag_o,
    output logic rx_valid_flag_o,
    output logic rx_overrun_flag_o,
    output logic rx_overrun_irq_o,
    output logic tx_underrun_irq_o,
    output logic dma_rx_error_o
);
    localparam int unsigned CNT_W = $clog2(ssp_pkg::FIFO_DEPTH + 1);

    ssp_pkg::ssp_state_t state;
    logic ref_q1, ref_q2, ref_q3;
    logic miso_q1, miso_q2;
    logic ref_tick;
    logic spi_on;
    logic [ssp_pkg::DIV_W-1:0] div_cnt;
    logic [ssp_pkg::DIV_W-1:0] half_period;
    logic half_done;
    logic [3:0] edge_cnt;
    logic [7:0] tx_byte;
    logic [7:0] rx_byte;
    logic [7:0] last_tx;
    logic pol_prev;
    logic spurious_pending;
    logic ovf_pending;
    logic tx_pop, tx_pop_valid;
    logic [7:0] tx_head;
    logic rx_push, rx_push_ready, rx_pop_valid;
    logic [7:0] rx_head;
    logic [CNT_W-1:0] tx_count, rx_count;
    logic start_fifo, start_auto, start_spur;
    logic lose_byte;

    // Bit position for a given bit step, honouring the shift order.
    function automatic logic [2:0] bit_index(input logic [2:0] step, input logic lsb_first);
        return lsb_first ? step : 3'(7 - step);
    endfunction

    initial begin
        if (ssp_pkg::CHAR_BITS != 8 || ssp_pkg::RATE_FIELD_MAX != 15) begin
            $error("ssp_spi_master serves only 8-bit characters and 4-bit rate fields");
        end
    end

    // Reference clock and MISO cross in through two flops before any use.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_q1 <= 1'b0;
            ref_q2 <= 1'b0;
            ref_q3 <= 1'b0;
            miso_q1 <= 1'b0;
            miso_q2 <= 1'b0;
        end else begin
            ref_q1 <= ref_clk_i;
            ref_q2 <= ref_q1;
            ref_q3 <= ref_q2;
            miso_q1 <= miso_i;
            miso_q2 <= miso_q1;
        end
    end

    assign ref_tick = ref_q2 && !ref_q3;
    assign spi_on = (serial_mode_select_i == ssp_pkg::MODE_SPI) && master_select_bit_i; // [R1] [R2] [R4]
    assign half_period = ssp_pkg::DIV_W'({16'h0000, rate_linear_reg_i} + 20'h0_0001) << rate_exponent_reg_i; // [R5] [R6]
    assign half_done = ref_tick && (div_cnt == half_period - 20'h0_0001);

    // A transfer needs a byte to send; reception never starts on its own.
    assign start_spur = (state == ssp_pkg::SSP_IDLE) && spi_on && spurious_pending && tx_pop_valid; // [R22]
    assign start_fifo = (state == ssp_pkg::SSP_IDLE) && spi_on && !spurious_pending && tx_pop_valid; // [R17]
    assign start_auto = (state == ssp_pkg::SSP_IDLE) && spi_on && !tx_pop_valid && auto_tx_enable_i; // [R18] [R19] [R21]
    assign tx_pop = start_fifo;
    assign rx_push = (state == ssp_pkg::SSP_DONE);
    assign lose_byte = rx_push && !rx_push_ready;

    ssp_fifo #(
        .WIDTH(ssp_pkg::CHAR_BITS),
        .DEPTH(ssp_pkg::FIFO_DEPTH)
    ) u_tx_fifo ( // [R10]
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .push_valid_i(tx_write_i),
        .push_ready_o(),
        .push_data_i(tx_data_i),
        .pop_valid_o(tx_pop_valid),
        .pop_ready_i(tx_pop),
        .pop_data_o(tx_head),
        .count_o(tx_count)
    );

    ssp_fifo #(
        .WIDTH(ssp_pkg::CHAR_BITS),
        .DEPTH(ssp_pkg::FIFO_DEPTH)
    ) u_rx_fifo ( // [R10]
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .push_valid_i(rx_push),
        .push_ready_o(rx_push_ready),
        .push_data_i(rx_byte),
        .pop_valid_o(rx_pop_valid),
        .pop_ready_i(rx_read_i),
        .pop_data_o(rx_head),
        .count_o(rx_count)
    );

    // Serial engine: sixteen clock edges make one eight-bit character.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ssp_pkg::SSP_IDLE;
            div_cnt <= ssp_pkg::RST_DIV;
            edge_cnt <= ssp_pkg::RST_EDGE;
            tx_byte <= ssp_pkg::RST_BYTE;
            rx_byte <= ssp_pkg::RST_BYTE;
            last_tx <= ssp_pkg::RST_BYTE;
            mosi_o <= 1'b0;
            serial_clock_pin_o <= 1'b0;
        end else begin
            unique case (state)
                ssp_pkg::SSP_IDLE: begin
                    serial_clock_pin_o <= clock_polarity_select_i; // [R7]
                    div_cnt <= ssp_pkg::RST_DIV;
                    edge_cnt <= ssp_pkg::RST_EDGE;
                    if (start_spur || start_fifo || start_auto) begin
                        logic [7:0] b;
                        b = start_spur ? ssp_pkg::SPURIOUS_BYTE : start_fifo ? tx_head :
                            repeat_select_bit_i ? last_tx : ssp_pkg::BUSY_TOKEN; // [R18] [R22]
                        tx_byte <= b;
                        if (!start_spur) begin
                            last_tx <= b;
                        end
                        // With phase 0 the first bit must stand before the first edge.
                        mosi_o <= b[bit_index(3'h0, bit_order_select_i)]; // [R7] [R8]
                        state <= ssp_pkg::SSP_SHIFT;
                    end
                end
                ssp_pkg::SSP_SHIFT: begin
                    if (!spi_on) begin
                        state <= ssp_pkg::SSP_IDLE; // [R1]
                    end else if (half_done) begin
                        div_cnt <= ssp_pkg::RST_DIV;
                        serial_clock_pin_o <= !serial_clock_pin_o;
                        edge_cnt <= edge_cnt + 4'h1;
                        if (edge_cnt[0] == clock_phase_select_i) begin
                            rx_byte[bit_index(edge_cnt[3:1], bit_order_select_i)] <= miso_q2; // [R8] [R3]
                        end else if (clock_phase_select_i) begin
                            mosi_o <= tx_byte[bit_index(edge_cnt[3:1], bit_order_select_i)]; // [R7]
                        end else if (edge_cnt != ssp_pkg::LAST_EDGE) begin
                            mosi_o <= tx_byte[bit_index(3'(edge_cnt[3:1] + 3'h1), bit_order_select_i)]; // [R7]
                        end
                        if (edge_cnt == ssp_pkg::LAST_EDGE) begin
                            state <= ssp_pkg::SSP_DONE; // [R3]
                        end
                    end else if (ref_tick) begin
                        div_cnt <= div_cnt + 20'h0_0001;
                    end
                end
                ssp_pkg::SSP_DONE: begin
                    state <= ssp_pkg::SSP_IDLE; // [R13] [R17]
                end
                default: begin
                    state <= ssp_pkg::SSP_IDLE;
                end
            endcase
        end
    end

    // A polarity fall while in SPI mode arms one stray byte until it is sent or the mode is cleared.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pol_prev <= 1'b0;
            spurious_pending <= 1'b0;
        end else begin
            pol_prev <= clock_polarity_select_i;
            if (pol_prev && !clock_polarity_select_i && serial_mode_select_i == ssp_pkg::MODE_SPI) begin
                spurious_pending <= 1'b1; // [R22]
            end else if (serial_mode_select_i == ssp_pkg::MODE_OFF || start_spur) begin
                spurious_pending <= 1'b0; // [R22]
            end
        end
    end

    // Status flags, all registered so every output leaves a flop.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_idle_flag_o <= 1'b1;
            tx_space_flag_o <= 1'b1;
            rx_valid_flag_o <= 1'b0;
            rx_data_o <= ssp_pkg::RST_BYTE;
            rx_overrun_irq_o <= 1'b0;
            tx_underrun_irq_o <= 1'b0;
        end else begin
            tx_idle_flag_o <= (tx_count == '0) && (state == ssp_pkg::SSP_IDLE); // [R11]
            tx_space_flag_o <= (tx_count != CNT_W'(ssp_pkg::FIFO_DEPTH)); // [R12]
            rx_valid_flag_o <= rx_pop_valid; // [R13]
            rx_data_o <= rx_head;
            rx_overrun_irq_o <= lose_byte; // [R14]
            tx_underrun_irq_o <= start_auto; // [R20]
        end
    end

    // Overrun and DMA error; a set in the same cycle as a clear wins.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_overrun_flag_o <= 1'b0;
            ovf_pending <= 1'b0;
            dma_rx_error_o <= 1'b0;
        end else begin
            if (lose_byte) begin
                rx_overrun_flag_o <= 1'b1; // [R14]
            end else if (rx_overrun_clear_i) begin
                rx_overrun_flag_o <= 1'b0;
            end
            if (lose_byte) begin
                ovf_pending <= 1'b1; // [R15]
            end else if (rx_count == '0) begin
                ovf_pending <= 1'b0;
            end
            if (ovf_pending && !lose_byte && rx_count == '0) begin
                dma_rx_error_o <= 1'b1; // [R15]
            end else if (dma_reset_bits_i || dma_buffer_reload_i) begin
                dma_rx_error_o <= 1'b0; // [R16]
            end
        end
    end

    a_space_full: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R12]
        tx_count == CNT_W'(ssp_pkg::FIFO_DEPTH) |=> !tx_space_flag_o)
        else $error("space flag set while transmit FIFO full");

    a_idle_clears: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R11]
        tx_count != '0 |=> !tx_idle_flag_o)
        else $error("idle flag set with bytes queued");

    a_rx_valid: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R13]
        rx_count != '0 |=> rx_valid_flag_o)
        else $error("valid flag low with unread bytes");

    a_overrun_raise: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R14]
        (rx_push && rx_count == CNT_W'(ssp_pkg::FIFO_DEPTH)) |=> rx_overrun_flag_o && rx_overrun_irq_o
            && rx_count == CNT_W'(ssp_pkg::FIFO_DEPTH))
        else $error("overrun not flagged or byte stored");

    a_dma_err_late: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R15]
        $rose(dma_rx_error_o) |-> $past(rx_count) == '0)
        else $error("DMA error before receive FIFO drained");

    a_dma_err_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R16]
        (dma_rx_error_o && !dma_reset_bits_i && !dma_buffer_reload_i) |=> dma_rx_error_o)
        else $error("DMA error cleared without reset or reload");

    a_start_gated: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R1]
        (state == ssp_pkg::SSP_IDLE ##1 state == ssp_pkg::SSP_SHIFT) |-> $past(spi_on))
        else $error("transfer started outside SPI master mode");

    a_underrun_auto: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R20]
        tx_underrun_irq_o |-> $past(tx_count) == '0 && $past(auto_tx_enable_i))
        else $error("underrun raised with data queued");

    a_edge_on_tick: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R5]
        (state == ssp_pkg::SSP_SHIFT && $past(state) == ssp_pkg::SSP_SHIFT && $changed(serial_clock_pin_o))
            |-> $past(ref_tick))
        else $error("serial clock edge without reference tick");

    a_rx_with_tx: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R17]
        rx_push |-> $past(state) == ssp_pkg::SSP_SHIFT && $past(edge_cnt) == ssp_pkg::LAST_EDGE)
        else $error("byte received without a full transmission");

    c_overrun: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) rx_overrun_irq_o);
    c_underrun: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) tx_underrun_irq_o);
    c_dma_error: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) $rose(dma_rx_error_o));
    c_spurious: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) start_spur);
endmodule

/* File: core/ssp_pkg.sv */
package ssp_pkg;

    // Character framing.
    localparam int unsigned CHAR_BITS = 8;
    localparam int unsigned FIFO_DEPTH = 4;
    localparam int unsigned EDGES_PER_CHAR = 2 * CHAR_BITS;
    localparam logic [3:0] LAST_EDGE = 4'hF;

    // Controller mode field.
    localparam int unsigned MODE_W = 2;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SPI = 2'h2;

    // Fill bytes.
    localparam logic [7:0] BUSY_TOKEN = 8'hFF;
    localparam logic [7:0] SPURIOUS_BYTE = 8'hFE;

    // Rate generator: half bit = (linear + 1) << exponent reference periods.
    localparam int unsigned REF_CLK_MHZ = 24;
    localparam int unsigned SYS_CLK_MHZ = 125;
    localparam int unsigned RATE_FIELD_W = 4;
    localparam int unsigned RATE_FIELD_MAX = 15;
    localparam int unsigned DIV_W = 20;

    // Values after reset.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [DIV_W-1:0] RST_DIV = 20'h0_0000;
    localparam logic [3:0] RST_EDGE = 4'h0;

    typedef enum logic [1:0] {
        SSP_IDLE = 2'b00,
        SSP_SHIFT = 2'b01,
        SSP_DONE = 2'b10
    } ssp_state_t;

endpackage

/* File: core/ssp_fifo.sv */
`timescale 1ns/10ps
module ssp_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic push_valid_i,
    output logic push_ready_o,
    input wire logic [WIDTH-1:0] push_data_i,
    output logic pop_valid_o,
    input wire logic pop_ready_i,
    output logic [WIDTH-1:0] pop_data_o,
    output logic [$clog2(DEPTH+1)-1:0] count_o
);
    localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("ssp_fifo needs a power-of-two depth of at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [$clog2(DEPTH+1)-1:0] count;
    logic do_push;
    logic do_pop;

    assign push_ready_o = (count != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign pop_valid_o = (count != '0);
    assign pop_data_o = mem[rd_ptr];
    assign count_o = count;
    assign do_push = push_valid_i && push_ready_o;
    assign do_pop = pop_ready_i && pop_valid_o;

    always_ff @(posedge clk_sys_i) begin
        if (do_push) begin
            mem[wr_ptr] <= push_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

/* File: verification/ssp_slave_model.sv */
`timescale 1ns/10ps
// Slave on the far side of the link. It answers reply_i plus its own character count, so a
// lost, doubled or misordered character shows up as a wrong value at the master.
module ssp_slave_model (
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic ssel_n_i,
    input wire logic cpol_i,
    input wire logic cpha_i,
    input wire logic lsb_i,
    input wire logic [7:0] reply_i,
    output logic miso_o,
    output logic [7:0] got_o,
    output int cnt_o
);
    logic [7:0] shreg;
    int k;
    int n;
    function automatic logic bit_of(input int idx);
        logic [7:0] b;
        b = reply_i + 8'(cnt_o);
        return lsb_i ? b[idx] : b[7-idx];
    endfunction
    initial begin
        miso_o = 1'h0;
        got_o = 8'h00;
        shreg = 8'h00;
        cnt_o = 0;
        k = 0;
        n = 0;
    end
    // The select is a software driven GPIO, not a pin of the master.
    always @(negedge ssel_n_i) begin
        k = 0;
        n = 0;
        miso_o = bit_of(0);
    end
    // A deselected slave inverts its line, so it does not keep showing the last bit.
    always @(posedge ssel_n_i) miso_o = ~miso_o;
    always @(sclk_i) begin
        if (!ssel_n_i) begin
            if ((sclk_i != cpol_i) ^ cpha_i) begin
                shreg[lsb_i ? n : 7 - n] = mosi_i;
                n = n + 1;
                if (n == 8) begin
                    got_o = shreg;
                    cnt_o = cnt_o + 1;
                    n = 0;
                end
            end else if (cpha_i) begin
                miso_o = bit_of(k);
                k = (k + 1) % 8;
            end else begin
                k = (k + 1) % 8;
                miso_o = bit_of(k);
            end
        end
    end
endmodule

/* File: verification/ssp_spi_master_bench.sv */
`timescale 1ns/10ps
module ssp_spi_master_bench;
    logic clk, rst_n, ref_clk, master, order, pha, pol, rpt, auto_tx, txw, rxr, ovclr, dmarst, dmarel;
    logic [1:0] mode;
    logic [3:0] rexp, rlin;
    logic [7:0] txd, rxd, reply, got;
    logic miso, mosi, sclk, idle, space, rxv, ovf, ovirq, undirq, dmaerr, ssel_n;
    int cnt, failures, checked;
    int und_n = 0;
    int ovf_n = 0;

    ssp_spi_master i_ssp_spi_master (.clk_sys_i(clk), .rst_n_i(rst_n), .ref_clk_i(ref_clk),
        .serial_mode_select_i(mode), .master_select_bit_i(master), .bit_order_select_i(order),
        .clock_phase_select_i(pha), .clock_polarity_select_i(pol), .repeat_select_bit_i(rpt),
        .auto_tx_enable_i(auto_tx), .rate_exponent_reg_i(rexp), .rate_linear_reg_i(rlin),
        .tx_write_i(txw), .tx_data_i(txd), .rx_read_i(rxr), .rx_overrun_clear_i(ovclr),
        .dma_reset_bits_i(dmarst), .dma_buffer_reload_i(dmarel), .miso_i(miso), .mosi_o(mosi),
        .serial_clock_pin_o(sclk), .rx_data_o(rxd), .tx_idle_flag_o(idle), .tx_space_flag_o(space),
        .rx_valid_flag_o(rxv), .rx_overrun_flag_o(ovf), .rx_overrun_irq_o(ovirq),
        .tx_underrun_irq_o(undirq), .dma_rx_error_o(dmaerr));
    // Only clock, data out and data in reach the slave, as in the three-wire master routing.
    ssp_slave_model i_ssp_slave_model (.sclk_i(sclk), .mosi_i(mosi), .ssel_n_i(ssel_n), .cpol_i(pol),
        .cpha_i(pha), .lsb_i(order), .reply_i(reply), .miso_o(miso), .got_o(got), .cnt_o(cnt));

    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    // The reference runs with an odd offset so its edges never land on a system clock edge.
    initial begin
        ref_clk = 1'h0;
        #13;
        forever #40 ref_clk = ~ref_clk;
    end
    always @(posedge clk) begin
        if (undirq === 1'h1) und_n <= und_n + 1;
        if (ovirq === 1'h1) ovf_n <= ovf_n + 1;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Ends one step past the edge so that outputs read afterwards have settled.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic push(input logic [7:0] b);
        @(posedge clk);
        txw <= 1'h1;
        txd <= b;
        @(posedge clk);
        txw <= 1'h0;
    endtask
    task automatic pop();
        @(posedge clk);
        rxr <= 1'h1;
        @(posedge clk);
        rxr <= 1'h0;
        cyc(3);
    endtask
    task automatic wait_idle();
        cyc(4);
        for (int i = 0; i < 20000 && idle !== 1'h1; i++) @(posedge clk);
        chk("idle_wait", idle, 1'h1);
        cyc(4);
    endtask
    task automatic wait_cnt(input int t);
        for (int i = 0; i < 20000 && cnt < t; i++) @(posedge clk);
        chk("frame_wait", cnt >= t, 1'h1);
    endtask
    // Mode goes to off before polarity moves, so no stray character is armed.
    task automatic cfg(input logic p, input logic h, input logic o);
        @(posedge clk);
        ssel_n <= 1'h1;
        mode <= ssp_pkg::MODE_OFF;
        cyc(2);
        pol <= p;
        pha <= h;
        order <= o;
        cyc(2);
        mode <= ssp_pkg::MODE_SPI;
        cyc(3);
        ssel_n <= 1'h0;
        cyc(1);
    endtask

    task automatic t_formats();
        int c0;
        for (int i = 0; i < 8; i++) begin
            reply <= 8'hA0 + 8'(i);
            cfg(i[0], i[1], i[2]);
            c0 = cnt;
            push(8'h3C + 8'(i));
            wait_idle();
            chk("slave_got", got, 8'h3C + 8'(i));
            chk("one_char", cnt - c0, 1);
            chk("sclk_idle", sclk, i[0]);
            chk("rx_valid", rxv, 1'h1);
            chk("rx_data", rxd, 8'(8'hA0 + 8'(i) + 8'(c0)));
            pop();
            chk("rx_empty", rxv, 1'h0);
        end
    endtask
    task automatic t_block();
        int c0;
        logic [1:0] md[3] = '{2'h0, 2'h1, 2'h3};
        cfg(1'h0, 1'h0, 1'h0);
        c0 = cnt;
        master <= 1'h0;
        for (int i = 0; i < 5; i++) push(8'h10 + 8'(i));
        cyc(3);
        chk("tx_space_full", space, 1'h0);
        chk("tx_idle_queued", idle, 1'h0);
        cyc(200);
        chk("no_frame_slave", cnt, c0);
        master <= 1'h1;
        for (int m = 0; m < 3; m++) begin
            mode <= md[m];
            cyc(200);
            chk("no_frame_mode", cnt, c0);
        end
        mode <= ssp_pkg::MODE_SPI;
        wait_cnt(c0 + 1);
        cyc(6);
        chk("tx_space_freed", space, 1'h1);
        wait_idle();
        chk("tx_frames", cnt - c0, 4);
        chk("last_sent", got, 8'h13);
        for (int i = 0; i < 4; i++) begin
            chk("rx_fifo", rxd, 8'(reply + 8'(c0 + i)));
            pop();
        end
        chk("rx_drained", rxv, 1'h0);
    endtask
    task automatic t_ovr(input logic rel);
        int c0, o0;
        c0 = cnt;
        o0 = ovf_n;
        for (int i = 0; i < 5; i++) push(8'h40 + 8'(i));
        wait_cnt(c0 + 5);
        wait_idle();
        chk("overrun_flag", ovf, 1'h1);
        chk("overrun_irq", ovf_n - o0, 1);
        chk("dma_err_early", dmaerr, 1'h0);
        for (int i = 0; i < 4; i++) begin
            chk("rx_kept", rxd, 8'(reply + 8'(c0 + i)));
            pop();
        end
        cyc(20);
        chk("dma_err_drained", dmaerr, 1'h1);
        @(posedge clk);
        if (rel) dmarel <= 1'h1;
        else dmarst <= 1'h1;
        ovclr <= 1'h1;
        @(posedge clk);
        dmarel <= 1'h0;
        dmarst <= 1'h0;
        ovclr <= 1'h0;
        cyc(3);
        chk("dma_err_clear", dmaerr, 1'h0);
        chk("overrun_clear", ovf, 1'h0);
    endtask
    task automatic t_auto();
        int c0, c1, u0;
        for (int r = 0; r < 2; r++) begin
            cfg(1'h0, 1'h0, 1'h0);
            rpt <= r[0];
            push(8'h5A);
            wait_idle();
            pop();
            c0 = cnt;
            u0 = und_n;
            @(posedge clk);
            auto_tx <= 1'h1;
            wait_cnt(c0 + 2);
            @(posedge clk);
            auto_tx <= 1'h0;
            wait_idle();
            c1 = cnt;
            chk("auto_byte", got, r[0] ? 8'h5A : ssp_pkg::BUSY_TOKEN);
            chk("underruns", und_n - u0, c1 - c0);
            cyc(300);
            chk("auto_stopped", cnt, c1);
            chk("rx_held", rxv, 1'h1);
            for (int i = c0; i < c1; i++) begin
                chk("auto_rx", rxd, 8'(reply + 8'(i)));
                pop();
            end
        end
    endtask
    task automatic t_spur();
        int c0;
        cfg(1'h1, 1'h0, 1'h0);
        @(posedge clk);
        ssel_n <= 1'h1;
        pol <= 1'h0;
        cyc(4);
        ssel_n <= 1'h0;
        c0 = cnt;
        push(8'h77);
        wait_cnt(c0 + 1);
        chk("stray_byte", got, ssp_pkg::SPURIOUS_BYTE);
        wait_idle();
        chk("intended_byte", got, 8'h77);
        chk("stray_count", cnt - c0, 2);
        pop();
        pop();
    endtask
    task automatic t_rate();
        int lins[3] = '{1, 15, 0};
        int exps[3] = '{1, 0, 3};
        realtime t0, dt, e;
        for (int i = 0; i < 3; i++) begin
            rlin <= 4'(lins[i]);
            rexp <= 4'(exps[i]);
            cfg(1'h0, 1'h0, 1'h0);
            push(8'h81);
            @(posedge sclk);
            t0 = $realtime;
            repeat (15) @(sclk);
            dt = $realtime - t0;
            e = 1200.0 * (lins[i] + 1) * (1 << exps[i]);
            chk("bit_rate", dt > e - 12.0 && dt < e + 12.0, 1'h1);
            wait_idle();
            pop();
        end
        rlin <= 4'h0;
        rexp <= 4'h0;
    endtask

    initial begin
        {master, order, pha, pol, rpt, auto_tx, txw, rxr, ovclr, dmarst, dmarel} = 11'h400;
        mode = ssp_pkg::MODE_OFF;
        rexp = 4'h0;
        rlin = 4'h0;
        txd = 8'h00;
        reply = 8'h5C;
        ssel_n = 1'h1;
        failures = 0;
        checked = 0;
        rst_n = 1'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        cyc(2);
        chk("reset_flags", {idle, space, rxv, ovf, dmaerr, sclk}, 6'h30);
        t_formats();
        t_block();
        t_ovr(1'h0);
        t_ovr(1'h1);
        t_auto();
        t_spur();
        t_rate();
        end_sim();
    end
    // The whole sequence takes well under 200 us; this limit only catches a hang.
    initial begin
        #600000;
        failures++;
        end_sim();
    end
endmodule
